// File: include/scg_defines.svh
// constants of the system clock generator: offsets, fields, reset values, timing
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH
// register indices; avalon address is the word index
`define SCG_IDX_TRIM 8'h96
`define SCG_IDX_DIV 8'h95
`define SCG_IDX_AUX1 8'hA2
`define SCG_IDX_STAT 8'h90
// trim and aux1 register fields
`define SCG_TRIM_RCSEL 7
`define SCG_TRIM_CLKOUT 6
`define SCG_TRIM_VAL 5:0
`define SCG_AUX1_LP 7
// factory trim: arbitrary neutral value
`define SCG_TRIM_FACTORY 8'h20
`define SCG_DIV_RESET 8'h00
// root source straps
`define SCG_SRC_XLO 3'h0
`define SCG_SRC_XMED 3'h1
`define SCG_SRC_XHI 3'h2
`define SCG_SRC_RC 3'h3
`define SCG_SRC_WDT 3'h4
`define SCG_SRC_EXT 3'h5
// wake-up timing
`define SCG_WAKE_XTAL 10'h3E0
`define SCG_WAKE_OTHER 10'h0E0
`define SCG_WAKE_US 60
`define SCG_CLK_MHZ 50
`define SCG_WAKE_DLY (`SCG_WAKE_US * `SCG_CLK_MHZ)
`endif

// File: include/scg_pkg.sv
// types of the system clock generator
package scg_pkg;
  typedef enum logic [1:0] {ST_LATCH, ST_CYCLES, ST_DELAY, ST_RUN} scg_state_t;
  typedef struct packed {
    logic [1:0] sy_rc;
    logic [1:0] sy_wd;
    logic [1:0] sy_xt;
    logic [1:0] sy_ex;
    logic [1:0] sy_pd;
    logic pr_root;
    scg_state_t state;
    logic [2:0] src;
    logic [9:0] wake_cnt;
    logic [11:0] dly_cnt;
    logic [7:0] div_reg;
    logic [7:0] div_act;
    logic [8:0] div_cnt;
    logic [7:0] trim;
    logic lp;
    logic cpu_en;
    logic per_ph;
    logic per_en;
    logic pin;
    logic pin_oe;
    logic waitreq;
    logic [7:0] rdata;
    logic running;
  } scg_state_s_t;
endpackage : scg_pkg

// File: verilog/scg_clock_gen.sv
// system clock generator: root select, wake-up timer, cpu divider, clock out, registers
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "scg_defines.svh"

// Summary of operation
// [RULE1] a machine cycle is two cpu clock periods
// [RULE2] root clock comes from one of four sources fixed by a programmed strap
// [RULE3] peripheral clock runs at half the cpu clock
// [RULE4] internal rc oscillator of nominal 7.373 MHz is a selectable root
// [RULE5] six-bit trim loads a factory value at reset; software may rewrite it
// [RULE6] crystal has low, medium and high speed range settings
// [RULE7] clock out works only when the crystal is unused by root and rtc
// [RULE8] clock out pin driven only while clock out enable is set
// [RULE9] clock out runs at half the cpu clock
// [RULE10] software should clear clock out enable before idle to save power
// [RULE11] watchdog oscillator of nominal 400 kHz is a selectable root
// [RULE12] external clock mode takes the root from the crystal input pin
// [RULE13] system enables the reset pin when the root exceeds 12 MHz; this block has no reset pin logic
// [RULE14] crystal root: wake-up holds cpu clock 992 root cycles plus 60 us
// [RULE15] other roots: wake-up holds cpu clock 224 root cycles plus 60 us
// [RULE16] programmable divider makes cpu clock with ratios up to 510
// [RULE17] divider value may be rewritten at any time
// [RULE18] software keeps the cpu clock at or below 12 MHz
// [RULE19] low-power select clears on any reset; set only at 8 MHz or less
// [RULE20] only power-on reset reloads the trim register
// [RULE21] trim register at 96h: rc select bit 7, clock out bit 6, trim 5:0
// [RULE22] divider changes take effect only at a cpu clock boundary
// [RULE23] cpu and peripheral clocks stay off until the wake-up count completes
module scg_clock_gen (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic other_reset_i,
  input wire logic [2:0] root_source_strap_i,
  input wire logic rtc_uses_crystal_i,
  input wire logic powerdown_i,
  input wire logic rc_osc_clock_i,
  input wire logic wdt_osc_clock_i,
  input wire logic crystal_osc_clock_i,
  input wire logic crystal_in_pin_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic cpu_clock_en_o,
  output logic periph_clock_en_o,
  output logic machine_cycle_o,
  output logic crystal_out_clock_pin_o,
  output logic crystal_out_clock_pin_oe_o,
  output logic low_power_clock_select_o,
  output logic [1:0] crystal_range_o,
  output logic clocks_running_o
);

  scg_pkg::scg_state_s_t st;
  scg_pkg::scg_state_s_t next_st;
  logic root_lvl;
  logic root_tick;
  logic wr_acc;
  logic xtal_src;

  // crystal ranges share one oscillator input; only the amplifier setting differs
  function automatic logic is_xtal(input logic [2:0] s);
    is_xtal = (s == `SCG_SRC_XLO) || (s == `SCG_SRC_XMED) || (s == `SCG_SRC_XHI);
  endfunction : is_xtal

  // terminal count of the cpu divider: 0 means divide by one, n means 2n
  function automatic logic [8:0] div_term(input logic [7:0] d);
    div_term = (d == 8'h00) ? 9'h000 : 9'({d, 1'b0} - 9'h001);
  endfunction : div_term

  // selected root level, taken from second sync stage only
  always_comb
  begin
    case (st.src)
      `SCG_SRC_RC: root_lvl = st.sy_rc[1]; // RULE4
      `SCG_SRC_WDT: root_lvl = st.sy_wd[1]; // RULE11
      `SCG_SRC_EXT: root_lvl = st.sy_ex[1]; // RULE12
      default: root_lvl = st.sy_xt[1]; // RULE6
    endcase
  end

  assign root_tick = root_lvl & ~st.pr_root;
  assign xtal_src = is_xtal(st.src);
  // a write lands only at the edge where waitrequest is seen low
  assign wr_acc = avs_write_i & ~st.waitreq;

  // next-state logic for the whole block
  always_comb
  begin
    next_st = st;
    next_st.sy_rc = {st.sy_rc[0], rc_osc_clock_i};
    next_st.sy_wd = {st.sy_wd[0], wdt_osc_clock_i};
    next_st.sy_xt = {st.sy_xt[0], crystal_osc_clock_i};
    next_st.sy_ex = {st.sy_ex[0], crystal_in_pin_i};
    next_st.sy_pd = {st.sy_pd[0], powerdown_i};
    next_st.pr_root = root_lvl;
    next_st.cpu_en = 1'b0;
    next_st.per_en = 1'b0;

    // wake-up sequencer; strap is caught once, after reset release
    case (st.state)
      scg_pkg::ST_LATCH:
      begin
        next_st.src = root_source_strap_i; // RULE2
        next_st.state = scg_pkg::ST_CYCLES;
        next_st.wake_cnt = 10'h000;
      end
      scg_pkg::ST_CYCLES:
      begin
        if (root_tick)
        begin
          next_st.wake_cnt = 10'(st.wake_cnt + 10'h001);
          if (st.wake_cnt == (xtal_src ? 10'(`SCG_WAKE_XTAL - 1) : 10'(`SCG_WAKE_OTHER - 1)))
          begin
            next_st.state = scg_pkg::ST_DELAY; // RULE14 RULE15
            next_st.dly_cnt = 12'h000;
          end
        end
      end
      scg_pkg::ST_DELAY:
      begin
        // fixed stabilisation time, the low end of the window
        next_st.dly_cnt = 12'(st.dly_cnt + 12'h001);
        if (st.dly_cnt == 12'(`SCG_WAKE_DLY - 1))
        begin
          next_st.state = scg_pkg::ST_RUN;
        end
      end
      scg_pkg::ST_RUN:
      begin
        if (st.sy_pd[1])
        begin
          next_st.state = scg_pkg::ST_CYCLES;
          next_st.wake_cnt = 10'h000;
        end
      end
      default: next_st.state = scg_pkg::ST_CYCLES;
    endcase
    next_st.running = (st.state == scg_pkg::ST_RUN) && !st.sy_pd[1]; // RULE23

    // cpu divider; the new ratio is picked up only when a period ends
    if (st.running && root_tick)
    begin
      if (st.div_cnt >= div_term(st.div_act))
      begin
        next_st.div_cnt = 9'h000;
        next_st.div_act = st.div_reg; // RULE22 RULE17
        next_st.cpu_en = 1'b1; // RULE16
        next_st.per_ph = ~st.per_ph;
        next_st.per_en = st.per_ph; // RULE3 RULE1
      end
      else
      begin
        next_st.div_cnt = 9'(st.div_cnt + 9'h001);
      end
    end

    // clock out toggles on every cpu tick, giving half the cpu rate
    next_st.pin_oe = st.trim[`SCG_TRIM_CLKOUT] && !xtal_src && !rtc_uses_crystal_i; // RULE7 RULE8
    if (!next_st.pin_oe)
    begin
      next_st.pin = 1'b0;
    end
    else if (next_st.cpu_en)
    begin
      next_st.pin = ~st.pin; // RULE9
    end

    // avalon slave: one wait cycle, then a single-cycle answer
    next_st.waitreq = 1'b1;
    if ((avs_read_i || avs_write_i) && st.waitreq)
    begin
      next_st.waitreq = 1'b0;
      case (avs_address_i)
        `SCG_IDX_TRIM: next_st.rdata = st.trim; // RULE21
        `SCG_IDX_DIV: next_st.rdata = st.div_reg;
        `SCG_IDX_AUX1: next_st.rdata = {st.lp, 7'h00};
        `SCG_IDX_STAT: next_st.rdata = {3'h0, st.running, st.src, st.pin_oe};
        default: next_st.rdata = 8'h00;
      endcase
    end
    if (wr_acc)
    begin
      case (avs_address_i)
        `SCG_IDX_TRIM: next_st.trim = avs_writedata_i[7:0]; // RULE5 RULE21
        `SCG_IDX_DIV: next_st.div_reg = avs_writedata_i[7:0]; // RULE17
        `SCG_IDX_AUX1: next_st.lp = avs_writedata_i[`SCG_AUX1_LP]; // RULE19
        default: next_st.lp = st.lp;
      endcase
    end

    // warm reset: restart wake-up and clear control, but keep trim
    if (other_reset_i)
    begin
      next_st.state = scg_pkg::ST_CYCLES;
      next_st.wake_cnt = 10'h000;
      next_st.lp = 1'b0; // RULE19
      next_st.div_reg = `SCG_DIV_RESET;
      next_st.div_act = `SCG_DIV_RESET;
      next_st.div_cnt = 9'h000;
      next_st.running = 1'b0;
      next_st.cpu_en = 1'b0;
      next_st.per_en = 1'b0;
      next_st.trim = wr_acc && (avs_address_i == `SCG_IDX_TRIM) ?
                     avs_writedata_i[7:0] : st.trim; // RULE20
    end
  end

  // state register; power-on reset is the only load of the factory trim
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st <= '0;
      st.state <= scg_pkg::ST_LATCH;
      st.trim <= `SCG_TRIM_FACTORY; // RULE5 RULE20
      st.div_reg <= `SCG_DIV_RESET;
      st.div_act <= `SCG_DIV_RESET;
      st.waitreq <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs come straight from the state register
  assign avs_readdata_o = {24'h00_0000, st.rdata};
  assign avs_waitrequest_o = st.waitreq;
  assign cpu_clock_en_o = st.cpu_en;
  assign periph_clock_en_o = st.per_en;
  assign machine_cycle_o = st.per_en;
  assign crystal_out_clock_pin_o = st.pin;
  assign crystal_out_clock_pin_oe_o = st.pin_oe;
  assign low_power_clock_select_o = st.lp;
  assign crystal_range_o = st.src[1:0];
  assign clocks_running_o = st.running;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_periph_half: assert property (periph_clock_en_o |-> cpu_clock_en_o) // RULE3
    else $error("peripheral tick without cpu tick");
  a_machine_two: assert property (machine_cycle_o |=> !machine_cycle_o) // RULE1
    else $error("machine cycle shorter than two cpu ticks");
  a_clkout_gate: assert property (crystal_out_clock_pin_oe_o |->
    $past(st.trim[`SCG_TRIM_CLKOUT]) && !is_xtal(st.src)) // RULE8
    else $error("clock out driven while disabled");
  a_clkout_xtal: assert property (rtc_uses_crystal_i |=> !crystal_out_clock_pin_oe_o) // RULE7
    else $error("clock out driven while rtc uses crystal");
  a_clkout_half: assert property ($changed(crystal_out_clock_pin_o) && crystal_out_clock_pin_oe_o
    && $past(crystal_out_clock_pin_oe_o) |-> cpu_clock_en_o) // RULE9
    else $error("clock out toggled off a cpu tick");
  a_wake_gate: assert property (!clocks_running_o |-> !cpu_clock_en_o) // RULE23
    else $error("cpu clock before wake-up done");
  a_wake_xtal: assert property (st.state == scg_pkg::ST_CYCLES && root_tick && xtal_src
    && st.wake_cnt == 10'(`SCG_WAKE_XTAL - 1) && !other_reset_i
    |=> st.state == scg_pkg::ST_DELAY) // RULE14
    else $error("crystal wake count wrong");
  a_wake_other: assert property (st.state == scg_pkg::ST_CYCLES && !xtal_src
    && st.wake_cnt < 10'(`SCG_WAKE_OTHER - 1) |=> st.state != scg_pkg::ST_DELAY) // RULE15
    else $error("short wake count left early");
  a_div_edge: assert property ($changed(st.div_act) && !$past(other_reset_i)
    |-> cpu_clock_en_o) // RULE22
    else $error("divider changed off a boundary");
  a_lp_clear: assert property (other_reset_i |=> !low_power_clock_select_o) // RULE19
    else $error("low power bit survived reset");
  a_trim_keep: assert property (other_reset_i && !wr_acc |=> st.trim == $past(st.trim)) // RULE20
    else $error("warm reset altered trim");
  a_src_fixed: assert property (st.state != scg_pkg::ST_LATCH |=> $stable(st.src)) // RULE2
    else $error("root source changed after latch");

  c_run: cover property ($rose(clocks_running_o));
  c_clkout: cover property (crystal_out_clock_pin_oe_o ##1 $changed(crystal_out_clock_pin_o));
  c_div_change: cover property ($changed(st.div_act));
  c_write: cover property (avs_write_i && !avs_waitrequest_o);

endmodule : scg_clock_gen
`default_nettype wire

// File: bench/scg_osc_model.sv
// oscillator, crystal and external clock model for the clock generator bench
`timescale 1ns/10ps
`default_nettype none
module scg_osc_model #(
  parameter int RC_HALF = 2,
  parameter int WD_HALF = 5,
  parameter int XT_HALF = 3,
  parameter int EX_HALF = 4
) (
  input wire logic clk_i,
  output logic rc_o,
  output logic wd_o,
  output logic xt_o,
  output logic ex_o
);
  logic [3:0] lvl = 4'h0;
  int cnt [4] = '{0, 0, 0, 0};
  int half [4];
  // distinct rates so the period seen at the cpu tells which source was picked
  assign half = '{RC_HALF, WD_HALF, XT_HALF, EX_HALF};
  // real oscillators run free, so every source keeps toggling at its own rate
  always @(posedge clk_i)
  begin
    for (int i = 0; i < 4; i++)
    begin
      cnt[i] <= (cnt[i] + 1 >= half[i]) ? 0 : cnt[i] + 1;
      if (cnt[i] + 1 >= half[i])
        lvl[i] <= ~lvl[i];
    end
  end
  assign rc_o = lvl[0];
  assign wd_o = lvl[1];
  assign xt_o = lvl[2];
  assign ex_o = lvl[3];
endmodule : scg_osc_model
`default_nettype wire

// File: bench/scg_testbench.sv
// self-checking bench of the system clock generator
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic other_reset_i = 1'b0;
  logic rtc = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [2:0] strap = 3'h3;
  logic [1:0] rng;
  logic wreq, cpu, per, mc, pin, oe, lp, run, rc, wd, xt, ex;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int early = 0;
  int n;
  int t0;
  logic [7:0] q;
  // root period of the rc source is 4 clk cycles
  // scaled rates; no root here needs the dedicated reset pin
  scg_osc_model osc (.clk_i(clk_i), .rc_o(rc), .wd_o(wd), .xt_o(xt), .ex_o(ex));
  scg_clock_gen uut (.clk_i(clk_i), .reset_i(reset_i), .other_reset_i(other_reset_i),
    .root_source_strap_i(strap), .rtc_uses_crystal_i(rtc), .powerdown_i(1'b0),
    .rc_osc_clock_i(rc), .wdt_osc_clock_i(wd), .crystal_osc_clock_i(xt),
    .crystal_in_pin_i(ex), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .cpu_clock_en_o(cpu), .periph_clock_en_o(per), .machine_cycle_o(mc),
    .crystal_out_clock_pin_o(pin), .crystal_out_clock_pin_oe_o(oe),
    .low_power_clock_select_o(lp), .crystal_range_o(rng), .clocks_running_o(run));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  // watch settled outputs mid-cycle
  always @(negedge clk_i)
  begin
    if (cpu === 1'b1 && run !== 1'b1)
      early++;
    `CHK("machine_cycle", 1'b0, mc & ~cpu)
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wreq !== 1'b0 && k < 50);
    if (k >= 50)
      miscompares++;
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(nm, e, q)
  endtask : rchk
  function automatic logic pick(input int s);
    return (s == 0) ? cpu : (s == 1) ? per : pin;
  endfunction : pick
  // cycles between two rising occurrences; bounded wait covers the /510 case
  task automatic gap(input int s);
    int k;
    int t;
    k = 0;
    t = 0;
    for (int i = 0; i < 2; i++)
    begin
      while (pick(s) !== 1'b0 && k < 6000)
      begin
        @(negedge clk_i);
        k++;
      end
      while (pick(s) !== 1'b1 && k < 6000)
      begin
        @(negedge clk_i);
        k++;
      end
      if (i == 0)
        t = cyc;
    end
    n = cyc - t;
    if (k >= 6000)
      miscompares++;
  endtask : gap
  task tally_and_finish();
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // a hang past twice the expected run length is a failure
  initial
  begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    t0 = cyc;
    rchk("trim reset", 8'h96, 8'h20);
    rchk("divider reset", 8'h95, 8'h00);
    rchk("aux reset", 8'hA2, 8'h00);
    bus(1'b1, 8'h10, 8'h5A);
    rchk("unmapped", 8'h10, 8'h00);
    // 224 root ticks of 4 cycles plus 3000 cycles, small sync slack either way
    while (run !== 1'b1 && cyc < 9000)
      @(negedge clk_i);
    `CHK("wake short", 1'b1, (cyc - t0 >= 3888))
    `CHK("wake long", 1'b1, (cyc - t0 <= 3912))
    `CHK("early pulses", 0, early)
    rchk("status", 8'h90, 8'h16);
    `CHK("range bits", 2'h3, rng)
    gap(0);
    `CHK("cpu div0", 4, n)
    gap(1);
    `CHK("periph", 8, n)
    bus(1'b1, 8'h95, 8'h03);
    gap(0);
    `CHK("cpu div3", 24, n)
    bus(1'b1, 8'h95, 8'hFF);
    gap(0);
    `CHK("cpu div510", 2040, n)
    bus(1'b1, 8'h95, 8'h00);
    gap(0);
    `CHK("cpu back", 4, n)
    bus(1'b1, 8'h96, 8'h60);
    gap(2);
    `CHK("clkout period", 8, n)
    `CHK("clkout oe", 1'b1, oe)
    rtc <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK("clkout rtc", 1'b0, oe)
    rtc <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK("clkout free", 1'b1, oe)
    bus(1'b1, 8'h96, 8'h15);
    repeat (4) @(posedge clk_i);
    `CHK("clkout off", 1'b0, oe)
    `CHK("pin off", 1'b0, pin)
    rchk("trim write", 8'h96, 8'h15);
    // slow the cpu clock before low-power select is allowed
    bus(1'b1, 8'h95, 8'h02);
    bus(1'b1, 8'hA2, 8'h80);
    repeat (2) @(posedge clk_i);
    `CHK("lp set", 1'b1, lp)
    other_reset_i <= 1'b1;
    @(posedge clk_i);
    other_reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK("lp cleared", 1'b0, lp)
    `CHK("rewake", 1'b0, run)
    rchk("trim kept", 8'h96, 8'h15);
    // power-on reset again with a crystal strap: long wake-up, factory trim back
    reset_i <= 1'b1;
    strap <= 3'h0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    t0 = cyc;
    rchk("trim por", 8'h96, 8'h20);
    bus(1'b1, 8'h96, 8'h40);
    // 992 root ticks of 6 cycles plus 3000 cycles
    while (run !== 1'b1 && cyc - t0 < 12000)
      @(negedge clk_i);
    `CHK("xtal wake short", 1'b1, (cyc - t0 >= 8944))
    `CHK("xtal wake long", 1'b1, (cyc - t0 <= 8968))
    `CHK("xtal range", 2'h0, rng)
    repeat (4) @(posedge clk_i);
    `CHK("clkout xtal", 1'b0, oe)
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
